// ### hw/scmdc_pkg.sv
// Constants and types for the sensor conditioner mode and diagnostic controller
package scmdc_pkg;

	// ********************************
	// Command codes
	// ********************************
	localparam logic [7:0] CMD_START_COMMAND = 8'ha9;
	localparam logic [7:0] CMD_START_SLEEP = 8'ha8;
	localparam logic [7:0] CMD_START_CYCLIC = 8'hab;
	localparam logic [7:0] CMD_WRITE_CHECKSUM = 8'h39;
	localparam logic [7:0] CMD_DIAG_MEAS_A = 8'hb0;
	localparam logic [7:0] CMD_DIAG_MEAS_B = 8'hb2;
	localparam logic [7:0] CMD_RAW_MEAS = 8'ha0;
	localparam logic [7:0] CMD_DAC_DIAG = 8'hc0;
	localparam logic [7:0] CMD_ADC_DIAG = 8'hc1;

	// ********************************
	// Register offsets
	// ********************************
	localparam logic [7:0] OFS_UPDATE_RATE = 8'h02;
	localparam logic [7:0] OFS_CYC_ENABLES = 8'h1e;
	localparam logic [7:0] OFS_PAUSE_COUNTS = 8'h20;
	localparam logic [7:0] OFS_CHECK_SELECT = 8'h21;
	localparam logic [7:0] OFS_CHECKSUM = 8'h35;
	localparam logic [7:0] OFS_DAC_INPUT = 8'h40;
	localparam logic [7:0] OFS_ADC_SELECT = 8'h41;
	localparam logic [7:0] OFS_PAUSE_EXT = 8'h42;
	localparam logic [7:0] OFS_CHECK_RESULT = 8'h43;
	localparam logic [7:0] OFS_MODE_STATUS = 8'h44;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h45;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h46;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h47;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [15:0] RST_UPDATE_RATE = 16'h0000;
	localparam logic [15:0] RST_CYC_ENABLES = 16'h0000;
	localparam logic [15:0] RST_PAUSE_COUNTS = 16'h0000;
	localparam logic [15:0] RST_CHECK_SELECT = 16'h0000;
	localparam logic [15:0] RST_CHECKSUM = 16'h0000;

	// ********************************
	// Field positions, cyclic enables
	// ********************************
	localparam int EN_SENSOR = 0;
	localparam int EN_TEMP = 1;
	localparam int EN_CHECK = 2;
	localparam int EN_SM_FIRST = 3;
	localparam int EN_SENSOR_AUTOZERO_FIRST = 4;
	localparam int EN_TM_FIRST = 5;
	localparam int EN_TEMPERATURE_AUTOZERO_FIRST = 6;
	localparam int EN_CHECK_FIRST = 7;
	// Pause fields: temperature 6 bits, autozero temp 6 bits in low word
	localparam int PZ_TM_LSB = 0;
	localparam int PZ_TEMPERATURE_AUTOZERO_LSB = 6;
	localparam int PZ_SM_LSB = 12;
	// Extension register: sensor autozero 4 bits, check 10 bits
	localparam int PZ_SENSOR_AUTOZERO_LSB = 0;
	localparam int PZ_SCC_LSB = 4;
	// Check select bit numbers
	localparam int CHK_SATURATION = 8;
	localparam int CHK_MEMORY = 9;
	localparam int NUM_CHECKS = 12;

	// Interrupt events
	localparam int IRQ_MODE = 0;
	localparam int IRQ_CRC_DONE = 1;
	localparam int IRQ_CHECK_DONE = 2;
	localparam int IRQ_SLOT = 3;
	localparam int NUM_IRQ = 4;

	// Checksum engine steps one word per cycle
	localparam int CRC_WORDS = 32;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_SEED = 16'hffff;

	// Restart hold after reset pin release
	localparam int RESTART_NS = 100;
	localparam int CLK_PERIOD_NS = 4;
	localparam int RESTART_CYCLES = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		MODE_COMMAND,
		MODE_SLEEP,
		MODE_CYCLIC
	} scmdc_mode_type;

endpackage

// ### hw/scmdc_ctrl.sv
// Command interpreter for mode switching, checksum and diagnostics
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module scmdc_ctrl #(
	parameter int MEM_WORDS = scmdc_pkg::CRC_WORDS
) (
	input wire logic i_mclk, // Core clock
	input wire logic i_rst, // Asynchronous reset, high
	input wire logic i_ce, // Clock enable
	input wire logic i_reset_pin_n, // Device reset pin, async
	input wire logic [7:0] i_cmd, // Command byte from serial front end
	input wire logic i_cmd_valid, // Command strobe
	input wire logic [15:0] i_mem_word, // Memory word at o_mem_addr
	input wire logic [scmdc_pkg::NUM_CHECKS-1:0] i_check_fail, // Raw check outcomes
	input wire logic [7:0] i_addr, // Register address
	input wire logic [15:0] i_wdata, // Register write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [15:0] o_rdata, // Read data, cycle after strobe
	output logic [7:0] o_mem_addr, // Memory word address
	output logic [1:0] o_mode, // Current mode
	output logic [15:0] o_dac_value, // Value to DAC
	output logic o_dac_diag, // DAC diagnostic active
	output logic [4:0] o_adc_pseudo, // Pseudo input select
	output logic o_adc_diag, // ADC inputs disconnected
	output logic [4:0] o_slot_tasks, // SM,SENSOR_AUTOZERO,TM,TEMPERATURE_AUTOZERO,SENSOR_CONNECTION_CHECK this slot
	output logic o_slot_strobe, // Slot boundary pulse
	output logic o_mem_error, // Memory error status
	output logic o_irq // Interrupt level
);
	localparam int NUM_CHK = scmdc_pkg::NUM_CHECKS;
	localparam int NI = scmdc_pkg::NUM_IRQ;
	// Restart window must cover the whole power-on checksum walk
	localparam int RESTART_LEN = (MEM_WORDS + 1 > scmdc_pkg::RESTART_CYCLES) ?
		MEM_WORDS + 1 : scmdc_pkg::RESTART_CYCLES;

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		logic rp_meta;
		logic rp_sync;
		logic [7:0] restart_cnt;
		scmdc_pkg::scmdc_mode_type mode;
		logic [15:0] update_rate;
		logic [15:0] cyc_en;
		logic [15:0] pause;
		logic [15:0] pause_ext;
		logic [15:0] chk_sel;
		logic [15:0] checksum;
		logic [15:0] dac_in;
		logic [4:0] adc_sel;
		logic dac_diag;
		logic adc_diag;
		logic [NUM_CHK-1:0] chk_res;
		logic mem_err;
		logic crc_busy;
		logic [7:0] crc_idx;
		logic [15:0] crc;
		logic [15:0] rate_cnt;
		logic first_slot;
		logic [5:0] tm_cnt;
		logic [5:0] temperature_autozero_cnt;
		logic [3:0] sm_cnt;
		logic [3:0] sensor_autozero_cnt;
		logic [9:0] scc_cnt;
		logic [4:0] tasks;
		logic slot_stb;
		logic [NI-1:0] irq_st;
		logic [NI-1:0] irq_en;
		logic irq;
		logic [15:0] rdata;
	} scmdc_state_type;

	scmdc_state_type s_reg;
	scmdc_state_type s_next;

	function automatic logic [15:0] scmdc_crc_step(input logic [15:0] c, input logic [15:0] d);
		logic [15:0] r;
		r = c;
		for (int b = 15; b >= 0; b--) begin
			if (r[15] ^ d[b]) begin
				r = {r[14:0], 1'b0} ^ scmdc_pkg::CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	// Next-value helpers
	logic [15:0] crc_new;
	logic [NI-1:0] ev;
	logic slot_tick;
	logic restart;

	always_comb begin
		s_next = s_reg;
		ev = '0;
		crc_new = scmdc_crc_step(s_reg.crc, i_mem_word);
		slot_tick = 1'b0;

		// ********************************
		// Reset pin
		// ********************************
		s_next.rp_meta = i_reset_pin_n;
		s_next.rp_sync = s_reg.rp_meta;
		restart = !s_reg.rp_sync;
		if (restart) begin
			s_next.restart_cnt = 8'(RESTART_LEN);
		end else if (s_reg.restart_cnt != 8'h00) begin
			s_next.restart_cnt = s_reg.restart_cnt - 8'h01;
		end

		// ********************************
		// Register writes and reads
		// ********************************
		s_next.rdata = 16'h0000;
		if (i_wr) begin
			unique case (i_addr)
				scmdc_pkg::OFS_UPDATE_RATE: s_next.update_rate = i_wdata;
				scmdc_pkg::OFS_CYC_ENABLES: s_next.cyc_en = i_wdata;
				scmdc_pkg::OFS_PAUSE_COUNTS: s_next.pause = i_wdata;
				scmdc_pkg::OFS_PAUSE_EXT: s_next.pause_ext = {2'b00, i_wdata[13:0]};
				scmdc_pkg::OFS_CHECK_SELECT: s_next.chk_sel = {4'h0, i_wdata[NUM_CHK-1:0]};
				scmdc_pkg::OFS_CHECKSUM: s_next.checksum = i_wdata;
				scmdc_pkg::OFS_DAC_INPUT: s_next.dac_in = i_wdata;
				scmdc_pkg::OFS_ADC_SELECT: s_next.adc_sel = i_wdata[4:0];
				scmdc_pkg::OFS_IRQ_ENABLE: s_next.irq_en = i_wdata[NI-1:0];
				default: ;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				scmdc_pkg::OFS_UPDATE_RATE: s_next.rdata = s_reg.update_rate;
				scmdc_pkg::OFS_CYC_ENABLES: s_next.rdata = s_reg.cyc_en;
				scmdc_pkg::OFS_PAUSE_COUNTS: s_next.rdata = s_reg.pause;
				scmdc_pkg::OFS_PAUSE_EXT: s_next.rdata = s_reg.pause_ext;
				scmdc_pkg::OFS_CHECK_SELECT: s_next.rdata = s_reg.chk_sel;
				scmdc_pkg::OFS_CHECKSUM: s_next.rdata = s_reg.checksum;
				scmdc_pkg::OFS_DAC_INPUT: s_next.rdata = s_reg.dac_in;
				scmdc_pkg::OFS_ADC_SELECT: s_next.rdata = {11'h000, s_reg.adc_sel};
				scmdc_pkg::OFS_CHECK_RESULT: s_next.rdata = {4'h0, s_reg.chk_res};
				scmdc_pkg::OFS_MODE_STATUS: s_next.rdata = {11'h000, s_reg.crc_busy,
					s_reg.mem_err, s_reg.adc_diag, s_reg.mode};
				scmdc_pkg::OFS_IRQ_STATUS: s_next.rdata = {12'h000, s_reg.irq_st};
				scmdc_pkg::OFS_IRQ_ENABLE: s_next.rdata = {12'h000, s_reg.irq_en};
				default: s_next.rdata = 16'h0000;
			endcase
		end

		// ********************************
		// Commands
		// ********************************
		// one code set whatever the serial front end
		if (i_cmd_valid && s_reg.restart_cnt == 8'h00 && !s_reg.crc_busy) begin
			unique case (i_cmd)
				scmdc_pkg::CMD_START_COMMAND: begin
					s_next.mode = scmdc_pkg::MODE_COMMAND;
					s_next.dac_diag = 1'b0;
					s_next.adc_diag = 1'b0;
					ev[scmdc_pkg::IRQ_MODE] = 1'b1;
				end
				scmdc_pkg::CMD_START_SLEEP: begin
					s_next.mode = scmdc_pkg::MODE_SLEEP;
					ev[scmdc_pkg::IRQ_MODE] = 1'b1;
				end
				// cyclic mode, sequence restarts at first slot
				scmdc_pkg::CMD_START_CYCLIC: begin
					s_next.mode = scmdc_pkg::MODE_CYCLIC;
					s_next.first_slot = 1'b1;
					s_next.rate_cnt = 16'h0000;
					s_next.tm_cnt = '0;
					s_next.temperature_autozero_cnt = '0;
					s_next.sm_cnt = '0;
					s_next.sensor_autozero_cnt = '0;
					s_next.scc_cnt = '0;
					ev[scmdc_pkg::IRQ_MODE] = 1'b1;
				end
				scmdc_pkg::CMD_WRITE_CHECKSUM: begin
					s_next.crc_busy = 1'b1;
					s_next.crc_idx = 8'h00;
					s_next.crc = scmdc_pkg::CRC_SEED;
				end
				// selected checks only; saturation allowed here
				scmdc_pkg::CMD_DIAG_MEAS_A, scmdc_pkg::CMD_DIAG_MEAS_B: begin
					s_next.chk_res = i_check_fail & s_reg.chk_sel[NUM_CHK-1:0];
					s_next.chk_res[scmdc_pkg::CHK_MEMORY] =
						s_reg.mem_err & s_reg.chk_sel[scmdc_pkg::CHK_MEMORY];
					ev[scmdc_pkg::IRQ_CHECK_DONE] = 1'b1;
				end
				scmdc_pkg::CMD_RAW_MEAS: begin
					s_next.chk_res[scmdc_pkg::CHK_SATURATION] = 1'b0;
				end
				// drive DAC input to analog output
				scmdc_pkg::CMD_DAC_DIAG: s_next.dac_diag = 1'b1;
				// pseudo input in place of pins
				scmdc_pkg::CMD_ADC_DIAG: s_next.adc_diag = 1'b1;
				default: ;
			endcase
		end

		// one memory word per cycle, result into checksum register
		if (s_reg.crc_busy) begin
			s_next.crc = crc_new;
			s_next.crc_idx = s_reg.crc_idx + 8'h01;
			if (s_reg.crc_idx == 8'(MEM_WORDS - 1)) begin
				s_next.crc_busy = 1'b0;
				s_next.checksum = crc_new;
				ev[scmdc_pkg::IRQ_CRC_DONE] = 1'b1;
			end
		end

		// ********************************
		// Cyclic sequence
		// ********************************
		s_next.slot_stb = 1'b0;
		s_next.tasks = 5'h00;
		if (s_reg.mode == scmdc_pkg::MODE_CYCLIC) begin
			if (s_reg.rate_cnt >= s_reg.update_rate) begin
				s_next.rate_cnt = 16'h0000;
				slot_tick = 1'b1;
			end else begin
				s_next.rate_cnt = s_reg.rate_cnt + 16'h0001;
			end
		end
		if (slot_tick) begin
			s_next.slot_stb = 1'b1;
			s_next.first_slot = 1'b0;
			ev[scmdc_pkg::IRQ_SLOT] = 1'b1;
			// task runs when its pause counter equals its pause field, then that counter clears
			if (s_reg.cyc_en[scmdc_pkg::EN_SENSOR]) begin
				s_next.tasks[4] = s_reg.first_slot ? s_reg.cyc_en[scmdc_pkg::EN_SM_FIRST]
					: (s_reg.sm_cnt == s_reg.pause[scmdc_pkg::PZ_SM_LSB +: 4]);
				s_next.tasks[3] = s_reg.first_slot ? s_reg.cyc_en[scmdc_pkg::EN_SENSOR_AUTOZERO_FIRST]
					: (s_reg.sensor_autozero_cnt == s_reg.pause_ext[scmdc_pkg::PZ_SENSOR_AUTOZERO_LSB +: 4]);
				s_next.sm_cnt = s_next.tasks[4] ? 4'h0 : s_reg.sm_cnt + 4'h1;
				s_next.sensor_autozero_cnt = s_next.tasks[3] ? 4'h0 : s_reg.sensor_autozero_cnt + 4'h1;
			end
			if (s_reg.cyc_en[scmdc_pkg::EN_TEMP]) begin
				s_next.tasks[2] = s_reg.first_slot ? s_reg.cyc_en[scmdc_pkg::EN_TM_FIRST]
					: (s_reg.tm_cnt == s_reg.pause[scmdc_pkg::PZ_TM_LSB +: 6]);
				s_next.tasks[1] = s_reg.first_slot ? s_reg.cyc_en[scmdc_pkg::EN_TEMPERATURE_AUTOZERO_FIRST]
					: (s_reg.temperature_autozero_cnt == s_reg.pause[scmdc_pkg::PZ_TEMPERATURE_AUTOZERO_LSB +: 6]);
				s_next.tm_cnt = s_next.tasks[2] ? 6'h00 : s_reg.tm_cnt + 6'h01;
				s_next.temperature_autozero_cnt = s_next.tasks[1] ? 6'h00 : s_reg.temperature_autozero_cnt + 6'h01;
			end
			if (s_reg.cyc_en[scmdc_pkg::EN_CHECK]) begin
				s_next.tasks[0] = s_reg.first_slot ? s_reg.cyc_en[scmdc_pkg::EN_CHECK_FIRST]
					: (s_reg.scc_cnt == s_reg.pause_ext[scmdc_pkg::PZ_SCC_LSB +: 10]);
				s_next.scc_cnt = s_next.tasks[0] ? 10'h000 : s_reg.scc_cnt + 10'h001;
			end
		end

		// ********************************
		// Interrupts, set wins over clear
		// ********************************
		if (i_wr && i_addr == scmdc_pkg::OFS_IRQ_CLEAR) begin
			s_next.irq_st = s_reg.irq_st & ~i_wdata[NI-1:0];
		end
		s_next.irq_st = s_next.irq_st | ev;
		s_next.irq = |(s_next.irq_st & s_next.irq_en);

		// ********************************
		// Device restart
		// ********************************
		// restart returns control state to power-on values
		if (restart) begin
			s_next.mode = scmdc_pkg::MODE_COMMAND;
			s_next.crc_busy = 1'b0;
			s_next.dac_diag = 1'b0;
			s_next.adc_diag = 1'b0;
			s_next.chk_res = '0;
			s_next.tasks = 5'h00;
			s_next.slot_stb = 1'b0;
			// memory error re-evaluated against stored checksum
			s_next.crc = scmdc_pkg::CRC_SEED;
			s_next.crc_idx = 8'h00;
			s_next.mem_err = 1'b1;
		end else if (s_reg.restart_cnt == 8'h01) begin
			s_next.crc_busy = 1'b0;
		end
		// Power-on check runs in the restart window, then compares
		if (s_reg.restart_cnt != 8'h00 && !restart) begin
			if (s_reg.crc_idx != 8'(MEM_WORDS)) begin
				s_next.crc = crc_new;
				s_next.crc_idx = s_reg.crc_idx + 8'h01;
			end
		end
		if (s_reg.restart_cnt == 8'h01) begin
			// matching checksum clears the memory error
			s_next.mem_err = (s_reg.crc_idx != 8'(MEM_WORDS)) || (s_reg.crc != s_reg.checksum);
			s_next.crc_idx = 8'h00;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '0;
			// Pin idle level, so no false restart follows reset
			s_reg.rp_meta <= 1'b1;
			s_reg.rp_sync <= 1'b1;
			s_reg.mode <= scmdc_pkg::MODE_COMMAND;
			s_reg.update_rate <= scmdc_pkg::RST_UPDATE_RATE;
			s_reg.cyc_en <= scmdc_pkg::RST_CYC_ENABLES;
			s_reg.pause <= scmdc_pkg::RST_PAUSE_COUNTS;
			s_reg.chk_sel <= scmdc_pkg::RST_CHECK_SELECT;
			s_reg.checksum <= scmdc_pkg::RST_CHECKSUM;
			s_reg.crc <= scmdc_pkg::CRC_SEED;
			s_reg.mem_err <= 1'b1;
		end else if (i_ce) begin
			s_reg <= s_next;
		end
	end

	assign o_rdata = s_reg.rdata;
	assign o_mem_addr = s_reg.crc_idx;
	assign o_mode = s_reg.mode;
	assign o_dac_value = s_reg.dac_in;
	assign o_dac_diag = s_reg.dac_diag;
	assign o_adc_pseudo = s_reg.adc_sel;
	assign o_adc_diag = s_reg.adc_diag;
	assign o_slot_tasks = s_reg.tasks;
	assign o_slot_strobe = s_reg.slot_stb;
	assign o_mem_error = s_reg.mem_err;
	assign o_irq = s_reg.irq;
endmodule

// ### testbench/scmdc_mem_model.sv
// Combinational memory that the checksum engine walks
`timescale 1ns/1ps
module scmdc_mem_model (
	input wire logic [7:0] i_addr, // Word address
	output logic [15:0] o_word // Word at that address
);
	// Address-dependent pattern so a stuck address shows in the sum
	assign o_word = {i_addr, ~i_addr} ^ 16'h5a00;
endmodule

// ### testbench/scmdc_ctrl_monitor.sv
// Port checker for the mode and diagnostic controller
`timescale 1ns/1ps
module scmdc_ctrl_monitor #(
	parameter int MEM_WORDS = 32
) (
	input wire logic i_mclk, // Clock
	input wire logic i_rst, // Reset
	input wire logic i_ce, // Clock enable
	input wire logic i_reset_pin_n, // Reset pin
	input wire logic [7:0] i_cmd, // Command
	input wire logic i_cmd_valid, // Command strobe
	input wire logic [15:0] i_mem_word, // Memory word
	input wire logic [11:0] i_check_fail, // Check outcomes
	input wire logic [7:0] i_addr, // Address
	input wire logic [15:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic [15:0] o_rdata, // Read data
	input wire logic [7:0] o_mem_addr, // Memory address
	input wire logic [1:0] o_mode, // Mode
	input wire logic [15:0] o_dac_value, // DAC value
	input wire logic o_dac_diag, // DAC diagnostic
	input wire logic [4:0] o_adc_pseudo, // Pseudo input
	input wire logic o_adc_diag, // ADC diagnostic
	input wire logic [4:0] o_slot_tasks, // Slot tasks
	input wire logic o_slot_strobe, // Slot pulse
	input wire logic o_mem_error, // Memory error
	input wire logic o_irq // Interrupt
);
	// Conservative quiet window: commands may be dropped while busy
	int quiet;
	logic take;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			quiet <= 100;
		end else if (!i_reset_pin_n || (i_cmd_valid && i_cmd == scmdc_pkg::CMD_WRITE_CHECKSUM)) begin
			quiet <= MEM_WORDS + 40;
		end else if (quiet != 0) begin
			quiet <= quiet - 1;
		end
	end
	assign take = i_cmd_valid && i_ce && quiet == 0;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	a_cmd_mode: assert property (take &&
		i_cmd == scmdc_pkg::CMD_START_COMMAND |=> o_mode == 2'h0)
		else $error("Command mode not entered");
	a_sleep_mode: assert property (take &&
		i_cmd == scmdc_pkg::CMD_START_SLEEP |=> o_mode == 2'h1)
		else $error("Sleep mode not entered");
	a_cyclic_mode: assert property (take &&
		i_cmd == scmdc_pkg::CMD_START_CYCLIC |=> o_mode == 2'h2)
		else $error("Cyclic mode not entered");
	a_mode_legal: assert property (o_mode != 2'h3)
		else $error("Mode code out of range");
	a_slot_mode: assert property (o_slot_strobe |-> o_mode == 2'h2 || $past(o_mode) == 2'h2)
		else $error("Slot outside cyclic mode");
	a_tasks_idle: assert property (!o_slot_strobe |-> o_slot_tasks == 5'h00)
		else $error("Slot tasks without strobe");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("Read data outside answer cycle");
	a_err_reset: assert property ($fell(i_rst) |-> o_mem_error)
		else $error("Memory error not set after reset");
	a_dac_cause: assert property ($rose(o_dac_diag) |->
		$past(i_cmd_valid) && $past(i_cmd) == scmdc_pkg::CMD_DAC_DIAG)
		else $error("DAC diagnostic without command");
	a_adc_cause: assert property ($rose(o_adc_diag) |->
		$past(i_cmd_valid) && $past(i_cmd) == scmdc_pkg::CMD_ADC_DIAG)
		else $error("ADC diagnostic without command");
endmodule
bind scmdc_ctrl scmdc_ctrl_monitor #(.MEM_WORDS(MEM_WORDS)) u_mon (.i_mclk(i_mclk), .i_rst(i_rst),
	.i_ce(i_ce), .i_reset_pin_n(i_reset_pin_n), .i_cmd(i_cmd), .i_cmd_valid(i_cmd_valid),
	.i_mem_word(i_mem_word), .i_check_fail(i_check_fail), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .o_mode(o_mode),
	.o_dac_value(o_dac_value), .o_dac_diag(o_dac_diag), .o_adc_pseudo(o_adc_pseudo),
	.o_adc_diag(o_adc_diag), .o_slot_tasks(o_slot_tasks), .o_slot_strobe(o_slot_strobe),
	.o_mem_error(o_mem_error), .o_irq(o_irq));

// ### testbench/scmdc_ctrl_bench.sv
// Self-checking bench for the mode and diagnostic controller
`timescale 1ns/1ps
module scmdc_ctrl_bench;
	localparam int MW = 32;
	logic clk = 1'b0, rst = 1'b1, pin_n = 1'b1, cmd_v = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
	logic ce = 1'b1;
	logic [7:0] cmd = 8'h00, addr = 8'h00, maddr;
	logic [15:0] wdata = 16'h0000, mword, rdata, dac, v, s;
	logic [11:0] fail = 12'h000;
	logic [1:0] mode;
	logic [4:0] pseudo, tasks, exp_tasks = 5'h00;
	logic dac_diag, adc_diag, strobe, mem_err, irq;
	logic [31:0] lfsr = 32'h3979;
	logic [15:0] exp_q[$], msk_q[$];
	int err_count = 0, n_tests = 0, cycles = 0, last_slot = 0, exp_gap = 0;
	logic [7:0] ofs[6] = '{scmdc_pkg::OFS_UPDATE_RATE, scmdc_pkg::OFS_CYC_ENABLES,
		scmdc_pkg::OFS_PAUSE_COUNTS, scmdc_pkg::OFS_CHECK_SELECT, scmdc_pkg::OFS_CHECKSUM,
		scmdc_pkg::OFS_PAUSE_EXT};
	logic [15:0] fmsk[6] = '{16'hffff, 16'h00ff, 16'hffff, 16'h0fff, 16'hffff, 16'h3fff};
	logic [7:0] cmds[4] = '{scmdc_pkg::CMD_START_SLEEP, scmdc_pkg::CMD_START_CYCLIC, 8'h55,
		scmdc_pkg::CMD_START_COMMAND};
	logic [1:0] modes[4] = '{2'h1, 2'h2, 2'h2, 2'h0};
	always #2 clk = ~clk;
	scmdc_mem_model MEM (.i_addr(maddr), .o_word(mword));
	scmdc_ctrl #(.MEM_WORDS(MW)) DUT (.i_mclk(clk), .i_rst(rst), .i_ce(ce), .i_reset_pin_n(pin_n),
		.i_cmd(cmd), .i_cmd_valid(cmd_v), .i_mem_word(mword), .i_check_fail(fail), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_mem_addr(maddr), .o_mode(mode),
		.o_dac_value(dac), .o_dac_diag(dac_diag), .o_adc_pseudo(pseudo), .o_adc_diag(adc_diag),
		.o_slot_tasks(tasks), .o_slot_strobe(strobe), .o_mem_error(mem_err), .o_irq(irq));
	// ********************************
	// Shared tasks
	// ********************************
	function automatic void rnd(output logic [15:0] r);
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		r = lfsr[15:0];
	endfunction
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Outputs settled one time unit past the edge on return
	task automatic send(input logic [7:0] c);
		@(posedge clk);
		cmd <= c;
		cmd_v <= 1'b1;
		@(posedge clk);
		cmd_v <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	function automatic logic [15:0] crc_ref();
		logic [15:0] c;
		c = scmdc_pkg::CRC_SEED;
		for (int i = 0; i < MW; i++) begin
			c = c ^ ({i[7:0], ~i[7:0]} ^ 16'h5a00);
			for (int b = 0; b < 16; b++) begin
				c = c[15] ? ((c << 1) ^ scmdc_pkg::CRC_POLY) : (c << 1);
			end
		end
		return c;
	endfunction
	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Result watcher: read answers, slot pulses, hang limit
	always @(posedge clk) begin
		cycles++;
		rd_d <= rd;
		if (rd_d) begin
			check("read data", exp_q[0], rdata & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
		if (strobe === 1'b1) begin
			if (exp_tasks != 5'h00) check("slot tasks", {11'h0, exp_tasks}, {11'h0, tasks});
			if (exp_gap != 0 && last_slot != 0) begin
				check("slot gap", 16'(exp_gap), 16'(cycles - last_slot));
			end
			last_slot = cycles;
		end
		if (cycles == 6000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		foreach (ofs[i]) rd_reg(ofs[i], 16'h0000, 16'hffff);
		rd_reg(scmdc_pkg::OFS_MODE_STATUS, 16'h0008, 16'h000f);
		foreach (ofs[i]) begin
			rnd(v);
			wr_reg(ofs[i], v);
			rd_reg(ofs[i], v, fmsk[i]);
		end
		wr_reg(8'h7f, 16'hffff);
		rd_reg(8'h7f, 16'h0000, 16'hffff);
		wr_reg(scmdc_pkg::OFS_MODE_STATUS, 16'h0003);
		rd_reg(scmdc_pkg::OFS_MODE_STATUS, 16'h0000, 16'h0003);
		repeat (40) @(posedge clk);
		foreach (cmds[i]) begin
			send(cmds[i]);
			rd_reg(scmdc_pkg::OFS_MODE_STATUS, {14'h0, modes[i]}, 16'h0003);
		end
		// Clock enable low: the command must be lost
		@(posedge clk);
		ce <= 1'b0;
		send(scmdc_pkg::CMD_START_SLEEP);
		@(posedge clk);
		ce <= 1'b1;
		rd_reg(scmdc_pkg::OFS_MODE_STATUS, 16'h0000, 16'h0003);
		wr_reg(scmdc_pkg::OFS_UPDATE_RATE, 16'h0003);
		wr_reg(scmdc_pkg::OFS_CYC_ENABLES, 16'h00ff);
		wr_reg(scmdc_pkg::OFS_PAUSE_COUNTS, 16'h0000);
		wr_reg(scmdc_pkg::OFS_PAUSE_EXT, 16'h0000);
		wr_reg(scmdc_pkg::OFS_IRQ_CLEAR, 16'h000f);
		wr_reg(scmdc_pkg::OFS_IRQ_ENABLE, 16'h0008);
		last_slot = 0;
		exp_gap = 4;
		exp_tasks = 5'h1f;
		send(scmdc_pkg::CMD_START_CYCLIC);
		repeat (20) @(posedge clk);
		#1;
		check("irq raised", 16'h0001, {15'h0, irq});
		rd_reg(scmdc_pkg::OFS_IRQ_STATUS, 16'h0008, 16'h0008);
		wr_reg(scmdc_pkg::OFS_IRQ_ENABLE, 16'h0000);
		repeat (2) @(posedge clk);
		#1;
		check("irq masked", 16'h0000, {15'h0, irq});
		exp_gap = 0;
		send(scmdc_pkg::CMD_START_COMMAND);
		exp_tasks = 5'h00;
		wr_reg(scmdc_pkg::OFS_IRQ_CLEAR, 16'h000f);
		wr_reg(scmdc_pkg::OFS_IRQ_ENABLE, 16'h0008);
		repeat (2) @(posedge clk);
		#1;
		check("irq cleared", 16'h0000, {15'h0, irq});
		rnd(v);
		wr_reg(scmdc_pkg::OFS_DAC_INPUT, v);
		send(scmdc_pkg::CMD_DAC_DIAG);
		check("dac value", v, dac);
		check("dac diag", 16'h0001, {15'h0, dac_diag});
		wr_reg(scmdc_pkg::OFS_ADC_SELECT, 16'h001f);
		send(scmdc_pkg::CMD_ADC_DIAG);
		check("adc select", 16'h001f, {11'h0, pseudo});
		rd_reg(scmdc_pkg::OFS_MODE_STATUS, 16'h0004, 16'h0004);
		for (int k = 0; k < 2; k++) begin
			rnd(v);
			rnd(s);
			s = (s & 16'h0dff) | 16'h0100;
			fail <= v[11:0] | 12'h100;
			wr_reg(scmdc_pkg::OFS_CHECK_SELECT, s);
			send(k == 0 ? scmdc_pkg::CMD_DIAG_MEAS_A : scmdc_pkg::CMD_DIAG_MEAS_B);
			rd_reg(scmdc_pkg::OFS_CHECK_RESULT, (v | 16'h0100) & s, 16'h0dff);
			send(scmdc_pkg::CMD_RAW_MEAS);
			rd_reg(scmdc_pkg::OFS_CHECK_RESULT, 16'h0000, 16'h0100);
		end
		send(scmdc_pkg::CMD_WRITE_CHECKSUM);
		repeat (MW + 8) @(posedge clk);
		rd_reg(scmdc_pkg::OFS_CHECKSUM, crc_ref(), 16'hffff);
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		pin_n <= 1'b1;
		repeat (100) @(posedge clk);
		rd_reg(scmdc_pkg::OFS_MODE_STATUS, 16'h0000, 16'h0018);
		rd_reg(scmdc_pkg::OFS_CHECKSUM, crc_ref(), 16'hffff);
		repeat (3) @(posedge clk);
		#1;
		check("memory error", 16'h0000, {15'h0, mem_err});
		report_and_stop();
	end
endmodule
